// [design/cfe_filter_ctrl.v]
`timescale 1ns/1ps
`include "cfe_map.vh"

module cfe_filter_ctrl (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        resetn,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Received message from the protocol engine
   input  wire        rx_msg_valid,
   input  wire        rx_msg_ext,
   input  wire [31:0] rx_msg_id,
   // Acceptance code and mask banks, byte k of each in bits 8k+7..8k
   input  wire [63:0] acceptance_code_bits,
   input  wire [63:0] acceptance_mask_bits,
   // Protocol engine status
   input  wire        init_acknowledge,
   input  wire        sleep_acknowledge,
   input  wire        busoff_entry,
   input  wire [7:0]  rx_error_count,
   input  wire [7:0]  tx_error_count,
   // Controls to the protocol engine
   output reg         init_request,
   output reg         sleep_request,
   output reg         busoff_recovery_req,
   output reg         rx_foreground_load,
   output reg  [31:0] rx_foreground_id,
   output reg         irq
);

   // Stored fields
   reg  [1:0]  layout_ff;
   reg  [2:0]  hit_ff;
   reg         hold_ff;
   reg         busoff_user_recovery_mode_ff;
   reg  [2:0]  irq_sts_ff;
   reg  [2:0]  irq_en_ff;
   reg  [7:0]  rx_error_count_ff;
   reg  [7:0]  tx_error_count_ff;

   // Next values and search results
   reg         nxt_accept;
   reg  [2:0]  nxt_hit;
   reg         found;
   reg  [7:0]  filt_vec;
   reg  [2:0]  ev;
   reg  [2:0]  nxt_sts;
   reg  [15:0] nxt_rdata;
   integer     i;

   // Decoded strobes and conditions
   wire        in_init;
   wire        wr_ctrl;
   wire        wr_hold;
   wire        wr_mode;
   wire        wr_irqen;
   wire        wr_irqcl;
   wire        hold_set;
   wire        hold_clr;
   wire        rx_drop;

   // Masked compare of one identifier byte
   function byte_hit;
      input [7:0] id_b;
      input [7:0] code_b;
      input [7:0] mask_b;
      begin
         byte_hit = &((~(id_b ^ code_b)) | mask_b);
      end
   endfunction

   // Identifier byte k of the message, byte 0 most significant
   function [7:0] id_byte;
      input [31:0] id;
      input [1:0]  k;
      begin
         id_byte = id[31 - 8 * k -: 8];
      end
   endfunction

   // One 32-bit filter; standard ids compare only the first two bytes
   function match32;
      input [31:0] id;
      input        ext;
      input [31:0] code;
      input [31:0] mask;
      begin
         match32 = byte_hit(id_byte(id, 2'h0), code[7:0], mask[7:0]) &
                   byte_hit(id_byte(id, 2'h1), code[15:8], mask[15:8]) &
                   (~ext |
                    (byte_hit(id_byte(id, 2'h2), code[23:16], mask[23:16]) &
                     byte_hit(id_byte(id, 2'h3), code[31:24], mask[31:24])));
      end
   endfunction

   // One 16-bit filter; the first two identifier bytes only
   function match16;
      input [31:0] id;
      input [15:0] code;
      input [15:0] mask;
      begin
         match16 = byte_hit(id_byte(id, 2'h0), code[7:0], mask[7:0]) &
                   byte_hit(id_byte(id, 2'h1), code[15:8], mask[15:8]);
      end
   endfunction

   // Lowest numbered set flag, with bit 3 telling whether any is set
   function [3:0] lowest_set;
      input [7:0] flags;
      integer     n;
      begin
         lowest_set = 4'h0;
         for (n = 7; n >= 0; n = n - 1) begin
            if (flags[n]) begin
               lowest_set = {1'b1, n[2:0]};
            end
         end
      end
   endfunction

   // Write strobe aimed at one register word
   function wr_at;
      input       wr;
      input [3:0] addr;
      input [3:0] target;
      begin
         wr_at = wr & (addr == target);
      end
   endfunction

   assign in_init  = init_request & init_acknowledge;
   assign wr_ctrl  = wr_at(reg_wr, reg_addr, `CFE_OFF_FILT_CTRL);
   assign wr_hold  = wr_at(reg_wr, reg_addr, `CFE_OFF_BO_HOLD);
   assign wr_mode  = wr_at(reg_wr, reg_addr, `CFE_OFF_MODE_CTRL);
   assign wr_irqen = wr_at(reg_wr, reg_addr, `CFE_OFF_IRQ_ENABLE);
   assign wr_irqcl = wr_at(reg_wr, reg_addr, `CFE_OFF_IRQ_CLEAR);

   // Filter search; several filters may match, the lowest number wins
   always @* begin
      filt_vec = 8'h00;
      case (layout_ff)
         `CFE_LAYOUT_32: begin
            for (i = 0; i < 2; i = i + 1) begin
               filt_vec[i] = match32(rx_msg_id, rx_msg_ext,
                                     acceptance_code_bits[32*i +: 32],
                                     acceptance_mask_bits[32*i +: 32]);
            end
         end
         `CFE_LAYOUT_16: begin
            for (i = 0; i < 4; i = i + 1) begin
               filt_vec[i] = match16(rx_msg_id,
                                     acceptance_code_bits[16*i +: 16],
                                     acceptance_mask_bits[16*i +: 16]);
            end
         end
         `CFE_LAYOUT_8: begin
            for (i = 0; i < 8; i = i + 1) begin
               filt_vec[i] = byte_hit(id_byte(rx_msg_id, 2'h0),
                                      acceptance_code_bits[8*i +: 8],
                                      acceptance_mask_bits[8*i +: 8]);
            end
         end
         default: filt_vec = 8'h00;
      endcase
      {found, nxt_hit} = lowest_set(filt_vec);
      nxt_accept       = found & rx_msg_valid;
   end

   // Layout field; hit and reserved bits are never stored from the bus
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         layout_ff <= `CFE_RST_LAYOUT;
      end else if (wr_ctrl && in_init) begin
         layout_ff <= reg_wdata[`CFE_LAYOUT_HI:`CFE_LAYOUT_LO];
      end
   end

   // Hit index follows the foreground buffer, never the background one
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hit_ff <= `CFE_RST_HIT;
      end else if (nxt_accept) begin
         hit_ff <= nxt_hit;
      end
   end

   // Foreground buffer load; rejected messages never reach it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_foreground_load <= 1'b0;
      end else begin
         rx_foreground_load <= nxt_accept;
      end
   end

   // Identifier kept until the next accepted message replaces it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_foreground_id <= 32'h00000000;
      end else if (nxt_accept) begin
         rx_foreground_id <= rx_msg_id;
      end
   end

   // Mode control bits
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         init_request  <= 1'b0;
         sleep_request <= 1'b0;
         busoff_user_recovery_mode_ff       <= 1'b0;
      end else if (wr_mode) begin
         init_request  <= reg_wdata[`CFE_MODE_INIT_REQUEST];
         sleep_request <= reg_wdata[`CFE_MODE_SLEEP_REQUEST];
         busoff_user_recovery_mode_ff       <= reg_wdata[`CFE_MODE_BUSOFF_USER_RECOVERY_MODE];
      end
   end

   // Set wins over a clear in the same cycle
   assign hold_set = busoff_entry & busoff_user_recovery_mode_ff;
   assign hold_clr = wr_hold & reg_wdata[0] & hold_ff;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hold_ff <= 1'b0;
      end else if (hold_set) begin
         hold_ff <= 1'b1;
      end else if (hold_clr) begin
         hold_ff <= 1'b0;
      end
   end

   // Recovery is asked for only by a clear that takes effect
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busoff_recovery_req <= 1'b0;
      end else begin
         busoff_recovery_req <= hold_clr & ~hold_set;
      end
   end

   // Counters are copied every cycle, so a read while the engine counts
   // may see a value that is one cycle old
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_error_count_ff <= `CFE_RST_COUNT;
      end else begin
         rx_error_count_ff <= rx_error_count;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_error_count_ff <= `CFE_RST_COUNT;
      end else begin
         tx_error_count_ff <= tx_error_count;
      end
   end

   assign rx_drop = rx_msg_valid & ~nxt_accept;

   // Events of this cycle; a clear in the same cycle never hides one
   always @* begin
      ev                  = 3'h0;
      ev[`CFE_IRQ_ACCEPT] = nxt_accept;
      ev[`CFE_IRQ_DROP]   = rx_drop;
      ev[`CFE_IRQ_BUSOFF] = busoff_entry;
      nxt_sts             = irq_sts_ff | ev;
      if (wr_irqcl) begin
         nxt_sts = (irq_sts_ff & ~reg_wdata[2:0]) | ev;
      end
   end

   // Interrupt enable, written whole
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_en_ff <= 3'h0;
      end else if (wr_irqen) begin
         irq_en_ff <= reg_wdata[2:0];
      end
   end

   // Level interrupt from the next status, so a clear drops it at once
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_sts_ff <= 3'h0;
         irq        <= 1'b0;
      end else begin
         irq_sts_ff <= nxt_sts;
         irq        <= |(nxt_sts & irq_en_ff);
      end
   end

   // Read data stand in the cycle after the strobe and are zero otherwise
   always @* begin
      nxt_rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `CFE_OFF_FILT_CTRL:
               nxt_rdata = {10'h000, layout_ff, 1'b0, hit_ff};
            `CFE_OFF_BO_HOLD:
               nxt_rdata = {15'h0000, hold_ff};
            `CFE_OFF_RX_ERR:
               nxt_rdata = {8'h00, rx_error_count_ff};
            `CFE_OFF_TX_ERR:
               nxt_rdata = {8'h00, tx_error_count_ff};
            `CFE_OFF_MODE_CTRL:
               nxt_rdata = {11'h000, sleep_acknowledge, init_acknowledge,
                            busoff_user_recovery_mode_ff, sleep_request, init_request};
            `CFE_OFF_IRQ_STATUS:
               nxt_rdata = {13'h0000, irq_sts_ff};
            `CFE_OFF_IRQ_ENABLE:
               nxt_rdata = {13'h0000, irq_en_ff};
            default:
               nxt_rdata = 16'h0000;
         endcase
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= nxt_rdata;
      end
   end

endmodule

// [design/cfe_map.vh]
`ifndef CFE_MAP_VH
`define CFE_MAP_VH

// Register offsets, word index on the register port
`define CFE_OFF_FILT_CTRL   4'hB
`define CFE_OFF_BO_HOLD     4'hC
`define CFE_OFF_RX_ERR      4'hE
`define CFE_OFF_TX_ERR      4'hF
`define CFE_OFF_MODE_CTRL   4'h0
`define CFE_OFF_IRQ_STATUS  4'h1
`define CFE_OFF_IRQ_ENABLE  4'h2
`define CFE_OFF_IRQ_CLEAR   4'h3

// Filter control fields
`define CFE_LAYOUT_HI       5
`define CFE_LAYOUT_LO       4
`define CFE_HIT_HI          2
`define CFE_HIT_LO          0

// Filter layouts
`define CFE_LAYOUT_32       2'h0
`define CFE_LAYOUT_16       2'h1
`define CFE_LAYOUT_8        2'h2
`define CFE_LAYOUT_CLOSED   2'h3

// Mode control bits
`define CFE_MODE_INIT_REQUEST     0
`define CFE_MODE_SLEEP_REQUEST      1
`define CFE_MODE_BUSOFF_USER_RECOVERY_MODE       2

// Interrupt status bits
`define CFE_IRQ_ACCEPT      0
`define CFE_IRQ_DROP        1
`define CFE_IRQ_BUSOFF      2

// Reset values
`define CFE_RST_LAYOUT      2'h0
`define CFE_RST_HIT         3'h0
`define CFE_RST_COUNT       8'h00

`endif

// [test/cfe_can_node.sv]
`timescale 1ns/1ps
module cfe_can_node #(parameter int ACK_DLY = 2) (
   // Clock
   input  logic        ref_clk,
   // Mode requests
   input  logic        init_request,
   input  logic        sleep_request,
   // Engine outputs
   output logic        init_acknowledge,
   output logic        sleep_acknowledge,
   output logic        rx_msg_valid = 0,
   output logic        rx_msg_ext = 0,
   output logic [31:0] rx_msg_id = 0,
   output logic        busoff_entry = 0,
   output logic [7:0]  rx_error_count = 0,
   output logic [7:0]  tx_error_count = 0
);
   // Acks lag requests, as a slow engine would
   logic [7:0] ish = 8'h00;
   logic [7:0] ssh = 8'h00;
   assign init_acknowledge = ish[ACK_DLY];
   assign sleep_acknowledge = ssh[ACK_DLY];
   always @(posedge ref_clk) begin
      ish <= {ish[6:0], init_request};
      ssh <= {ssh[6:0], sleep_request};
   end
   task send(input logic [31:0] id, input logic ext);
      @(posedge ref_clk);
      rx_msg_valid <= 1'b1;
      rx_msg_id <= id;
      rx_msg_ext <= ext;
      @(posedge ref_clk);
      rx_msg_valid <= 1'b0;
      // Stale id must not look valid
      rx_msg_id <= ~id;
      rx_msg_ext <= ~ext;
   endtask
   task busoff();
      @(posedge ref_clk);
      busoff_entry <= 1'b1;
      @(posedge ref_clk);
      busoff_entry <= 1'b0;
   endtask
   task cnt(input logic [7:0] r, t);
      rx_error_count <= r;
      tx_error_count <= t;
   endtask
endmodule

// [test/cfe_filter_ctrl_sva.sv]
`timescale 1ns/1ps
module cfe_chk (
   // Clock and reset
   input logic        ref_clk,
   input logic        resetn,
   // Register port
   input logic [3:0]  reg_addr,
   input logic [15:0] reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [15:0] reg_rdata,
   // Engine side
   input logic        rx_msg_valid,
   input logic [31:0] rx_msg_id,
   input logic        init_request,
   input logic        busoff_recovery_req,
   input logic        rx_foreground_load,
   input logic [31:0] rx_foreground_id
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire w1 = reg_wr && reg_addr == 4'hC && reg_wdata[0];
   wire w0 = reg_wr && reg_addr == 4'hC && !reg_wdata[0];
   wire wm = reg_wr && reg_addr == 4'h0;
   wire ib = reg_wdata[0];
   a_resv_zero: assert property (
      reg_rd && reg_addr == 4'hB |=> reg_rdata[15:6] == 10'h000
      && !reg_rdata[3]) else $error("reserved bits nonzero");
   a_rx_upper: assert property (
      reg_rd && reg_addr == 4'hE |=> reg_rdata[15:8] == 8'h00)
      else $error("rx count upper byte");
   a_tx_upper: assert property (
      reg_rd && reg_addr == 4'hF |=> reg_rdata[15:8] == 8'h00)
      else $error("tx count upper byte");
   a_load_cause: assert property (
      rx_foreground_load |-> $past(rx_msg_valid))
      else $error("load without message");
   a_fg_ident: assert property (
      rx_foreground_load |-> rx_foreground_id == $past(rx_msg_id))
      else $error("foreground id wrong");
   a_recov_cause: assert property (
      busoff_recovery_req |-> $past(w1)) else $error("stray recovery");
   a_zero_kept: assert property (
      w0 |=> !busoff_recovery_req) else $error("zero write recovered");
   a_init_bit: assert property (
      wm |=> init_request == $past(ib)) else $error("init bit wrong");
   c_load: cover property (rx_foreground_load);
   c_recov: cover property (busoff_recovery_req);
   c_hit: cover property (reg_rd && reg_addr == 4'hB ##1 reg_rdata[2]);
endmodule

// [test/cfe_filter_ctrl_tb_top.sv]
`timescale 1ns/1ps
module cfe_filter_ctrl_tb_top;
   logic        ref_clk, resetn, reg_wr, reg_rd, rx_msg_valid, rx_msg_ext;
   logic [3:0]  reg_addr, r;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [31:0] rx_msg_id, rx_foreground_id, id;
   logic [63:0] acceptance_code_bits, acceptance_mask_bits;
   logic        init_acknowledge, sleep_acknowledge, busoff_entry, irq;
   logic        init_request, sleep_request, busoff_recovery_req;
   logic        rx_foreground_load, acc, en, x;
   logic [7:0]  rx_error_count, tx_error_count, rc, tc;
   logic [2:0]  hit;
   int          err_count = 0, n_checks = 0, cyc = 0;
   cfe_filter_ctrl DUT (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .rx_msg_valid, .rx_msg_ext, .rx_msg_id,
      .acceptance_code_bits, .acceptance_mask_bits, .init_acknowledge,
      .sleep_acknowledge, .busoff_entry, .rx_error_count, .tx_error_count,
      .init_request, .sleep_request, .busoff_recovery_req,
      .rx_foreground_load, .rx_foreground_id, .irq);
   cfe_can_node #(.ACK_DLY(3)) u_node (.ref_clk, .init_request,
      .sleep_request, .init_acknowledge, .sleep_acknowledge, .rx_msg_valid,
      .rx_msg_ext, .rx_msg_id, .busoff_entry, .rx_error_count,
      .tx_error_count);
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         print_verdict;
      end
   end
   task print_verdict;
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string s, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Lowest matching filter wins; {found, index}
   function automatic logic [3:0] hit_of(logic [1:0] l, logic [31:0] v,
      logic x, logic [63:0] c, m);
      int n, w, k;
      logic ok;
      n = l == 0 ? 2 : l == 1 ? 4 : l == 2 ? 8 : 0;
      w = l == 0 ? (x ? 4 : 2) : l == 1 ? 2 : 1;
      for (int i = 0; i < n; i++) begin
         ok = 1;
         for (int j = 0; j < w; j++) begin
            k = i * (l == 0 ? 4 : l == 1 ? 2 : 1) + j;
            if (((v[31-8*j -: 8] ^ c[8*k +: 8]) & ~m[8*k +: 8]) != 0) ok = 0;
         end
         if (ok) return {1'b1, 3'(i)};
      end
      return 4'h0;
   endfunction
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, hit} = 0;
      {acceptance_code_bits, acceptance_mask_bits} = 0;
      void'($urandom(44));
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(4'hB, d); chk("filt", 16'h0000, d);
      rd(4'hC, d); chk("hold", 16'h0000, d);
      wr(4'hB, 16'h0020); rd(4'hB, d); chk("filt", 16'h0000, d);
      wr(4'h0, 16'h0005);
      while (init_acknowledge !== 1'b1) @(posedge ref_clk);
      rd(4'h0, d); chk("mode", 16'h000D, d);
      wr(4'hB, 16'hFFFF); rd(4'hB, d); chk("filt", 16'h0030, d);
      for (int l = 0; l < 4; l++) begin
         en = l != 2;
         wr(4'hB, 16'(l) << 4); wr(4'h3, 16'h0007); wr(4'h2, 16'(en));
         acc = 0;
         acceptance_code_bits <= {$urandom, $urandom};
         acceptance_mask_bits <= {$urandom | $urandom | $urandom,
                                  $urandom | $urandom | $urandom};
         repeat (12) begin
            id = $urandom;
            x = 1'($urandom);
            u_node.send(id, x);
            r = hit_of(2'(l), id, x, acceptance_code_bits,
               acceptance_mask_bits);
            #1 chk("load", 16'(r[3]), 16'(rx_foreground_load));
            if (r[3]) hit = r[2:0];
            acc = acc | r[3];
            chk("irq", 16'(acc & en), 16'(irq));
            rd(4'hB, d); chk("filt", 16'(l) << 4 | hit, d);
         end
      end
      u_node.busoff();
      rd(4'hC, d); chk("hold", 16'h0001, d);
      wr(4'hC, 16'h0000); rd(4'hC, d); chk("hold", 16'h0001, d);
      wr(4'hC, 16'h0001);
      #1 chk("recov", 16'h0001, 16'(busoff_recovery_req));
      rd(4'hC, d); chk("hold", 16'h0000, d);
      repeat (2) begin
         rc = 8'($urandom);
         tc = 8'($urandom);
         u_node.cnt(rc, tc);
         wr(4'hE, 16'hFFFF); wr(4'hF, 16'hFFFF);
         rd(4'hE, d); chk("rxcnt", {8'h00, rc}, d);
         rd(4'hF, d); chk("txcnt", {8'h00, tc}, d);
      end
      rd(4'h7, d); chk("unmapped", 16'h0000, d);
      print_verdict;
   end
endmodule
bind cfe_filter_ctrl cfe_chk u_chk (.ref_clk, .resetn, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_msg_valid, .rx_msg_id,
   .init_request, .busoff_recovery_req, .rx_foreground_load,
   .rx_foreground_id);
